// file: shared/adcct_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts of the converter link.
// Assumes: Word-indexed register ports on both ends.
// Notes: Definitions only.
`ifndef ADCCT_DEFINES_SVH
`define ADCCT_DEFINES_SVH

// Converter end register offsets.
`define ADCCT_OFF_MAIN 4'h0
`define ADCCT_OFF_TIMING 4'h1
`define ADCCT_OFF_DMA 4'h2
`define ADCCT_OFF_DSD 4'h3
`define ADCCT_OFF_MASK 4'h4
`define ADCCT_OFF_STAT 4'h5
`define ADCCT_OFF_DATA 4'h6

// Main configuration bits.
`define ADCCT_MAIN_START 0
`define ADCCT_MAIN_ABORT 1
`define ADCCT_MAIN_SCAN 2
`define ADCCT_MAIN_ETE 3
`define ADCCT_MAIN_HALF 4

// DMA enable bits.
`define ADCCT_DMA_EN 0
`define ADCCT_DMA_DMA_CLEAR_ON_READ 1

// Trigger end register offsets and bits.
`define ADCCT_OFF_EVT 4'h0
`define ADCCT_OFF_ACC 4'h1
`define ADCCT_OFF_CSTAT 4'h2
`define ADCCT_OFF_LAST 4'h3
`define ADCCT_OFF_CNT 4'h4
`define ADCCT_EVT_TM 0
`define ADCCT_EVT_TEN 1
`define ADCCT_EVT_CH_LO 2

// Reset values.
`define ADCCT_RST_MAIN 5'h00
`define ADCCT_RST_TIMING 2'h1
`define ADCCT_RST_DSD 8'h00
`define ADCCT_RST_MASK 8'h00
`define ADCCT_RST_EVT 5'h00

// Timing counts in converter clock cycles, and the no-channel code.
`define ADCCT_CONV_BASE 8'h0a
`define ADCCT_CMP_SAFE 2'h1
`define ADCCT_CTU_GATE_CYC 3
`define ADCCT_NO_CH 4'h8

`endif

// file: shared/adcct_pkg.sv
// Purpose: Types shared by both ends of the converter link.
// Assumes: Nothing beyond the defines header.
// Notes: Types only.
package adcct_pkg;
    typedef logic [15:0] adcct_word_t;
    typedef logic [3:0] adcct_addr_t;
    typedef logic [2:0] adcct_ch_t;
    typedef enum {ADC_IDLE, ADC_DECODE, ADC_CONVERT, ADC_DONE} adcct_state_t;
endpackage

// file: shared/adcct_link_if.sv
// Purpose: Trigger handshake and result stream between converter and trigger unit.
// Assumes: Both ends share clk_sys.
// Notes: One modport per end.
`timescale 1ns/1ps
`default_nettype none
interface adcct_link_if;
    logic trig;
    logic [2:0] trig_ch;
    logic next_cmd;
    logic dma_valid;
    logic dma_ready;
    logic [15:0] dma_data;
    modport adc (input trig, trig_ch, dma_ready, output next_cmd, dma_valid, dma_data);
    modport ctu (output trig, trig_ch, dma_ready, input next_cmd, dma_valid, dma_data);
endinterface
`default_nettype wire

// file: src/adcct_buf2.sv
// Purpose: Two-entry valid/ready buffer on the result path.
// Assumes: Single clock.
// Notes: in_ready does not depend on in_valid.
`timescale 1ns/1ps
`default_nettype none
module adcct_buf2 #(
    parameter int W = 16,
    parameter int D = 2
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    // Full means D words held; a narrower compare would wrap and block the empty buffer.
    assign in_ready = count_reg != (AW+1)'(D);
    assign out_valid = count_reg != '0;
    assign out_data = mem[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk_sys)
    begin
        if (push)
        begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(D - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(D - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // adcct_buf2
`default_nettype wire

// file: src/adcct_adc.sv
// Purpose: Converter control end: chains, scan, abort, trigger handshake, DMA request.
// Assumes: Software port strobes are one cycle; read data follow one cycle later.
// Notes: Known defects of the converter are reproduced on purpose.
`timescale 1ns/1ps
`default_nettype none
`include "adcct_defines.svh"
module adcct_adc (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Link to the trigger unit and DMA side
    adcct_link_if.adc link,
    // Software register port
    input wire adcct_pkg::adcct_addr_t reg_addr,
    input wire adcct_pkg::adcct_word_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output adcct_pkg::adcct_word_t reg_rdata,
    // Analog front end and mode control
    input wire logic [11:0] sample_data,
    input wire logic stop_req,
    output logic [2:0] mux_ch,
    output logic mux_decode
);
    import adcct_pkg::*;

    function automatic logic [3:0] adcct_find(input logic [7:0] mask, input logic [3:0] from);
        logic [3:0] r;
        r = `ADCCT_NO_CH;
        for (int i = 7; i >= 0; i--)
        begin
            if (mask[i] && (4'(i) >= from))
            begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    logic start_reg;
    logic abort_reg;
    logic scan_reg;
    logic ete_reg;
    logic half_reg;
    logic [1:0] cmp_field_reg;
    logic dma_en_reg;
    logic dma_clear_on_read_reg;
    logic [7:0] dsd_reg;
    logic [7:0] mask_reg;
    adcct_state_t state_reg;
    logic [7:0] cnt_reg;
    logic [3:0] cur_ch_reg;
    logic chain_reg;
    logic first_rep_reg;
    logic bug_active_reg;
    logic bug_pending_reg;
    logic stuck_reg;
    logic gated_reg;
    logic next_cmd_reg;
    adcct_word_t data_reg;
    adcct_word_t rdata_reg;

    logic [1:0] eff_cmp;
    logic [7:0] dly;
    logic [7:0] conv_len;
    logic [7:0] first_cnt;
    adcct_state_t first_state;
    logic [3:0] first_ch;
    logic [3:0] nxt_ch;
    logic nxt_is_last;
    logic can_run;
    logic start_chain;
    logic start_trig;
    logic abort_now;
    logic conv_done;
    logic chain_over;
    logic buf_in_ready;
    logic buf_out_valid;
    logic buf_out_ready;
    adcct_word_t result;
    logic wr_main;

    // The comparator can never select its fastest setting.
    assign eff_cmp = (cmp_field_reg == 2'h0) ? `ADCCT_CMP_SAFE : cmp_field_reg;
    // At half rate the low delay bit is lost, so odd values act as the even one below.
    assign dly = half_reg ? {1'b0, dsd_reg[7:1]} : dsd_reg;
    assign conv_len = `ADCCT_CONV_BASE + {6'h00, eff_cmp};
    assign first_cnt = (dly == 8'h00) ? conv_len : dly;
    assign first_state = (dly == 8'h00) ? ADC_CONVERT : ADC_DECODE;
    assign first_ch = adcct_find(mask_reg, 4'h0);
    assign nxt_ch = adcct_find(mask_reg, cur_ch_reg + 4'h1);
    assign nxt_is_last = adcct_find(mask_reg, nxt_ch + 4'h1) == `ADCCT_NO_CH;
    assign wr_main = reg_wr && (reg_addr == `ADCCT_OFF_MAIN);

    assign can_run = !gated_reg && !stuck_reg;
    assign start_chain = (state_reg == ADC_IDLE) && can_run && !ete_reg && start_reg
                         && !abort_reg && (mask_reg != 8'h00);
    // A trigger that lands while the clock is gated is simply lost.
    assign start_trig = (state_reg == ADC_IDLE) && can_run && ete_reg && link.trig;
    assign abort_now = abort_reg && chain_reg && (state_reg != ADC_IDLE) && can_run;
    assign conv_done = (state_reg == ADC_DONE) && can_run && (!dma_en_reg || buf_in_ready);
    // After an abort the last channel of the next chain is dropped.
    assign chain_over = (nxt_ch == `ADCCT_NO_CH) || (bug_active_reg && nxt_is_last);
    assign result = {1'b1, cur_ch_reg[2:0], sample_data};

    // The converter clock stops one cycle after the stop request.
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            gated_reg <= 1'b0;
        end
        else
        begin
            gated_reg <= stop_req;
        end
    end

    // Once the trigger state is corrupted only a reset revives it.
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            stuck_reg <= 1'b0;
        end
        else if (link.trig && !ete_reg && !gated_reg)
        begin
            stuck_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            {half_reg, ete_reg, scan_reg, abort_reg, start_reg} <= `ADCCT_RST_MAIN;
        end
        else if (wr_main)
        begin
            {half_reg, ete_reg, scan_reg, abort_reg, start_reg} <= reg_wdata[4:0];
        end
        else
        begin
            // The abort bit reads back high until the chain has stopped.
            if (abort_reg && (state_reg == ADC_IDLE))
            begin
                abort_reg <= 1'b0;
            end
            if (conv_done && chain_reg && !first_rep_reg && chain_over && !scan_reg)
            begin
                start_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            cmp_field_reg <= `ADCCT_RST_TIMING;
            dma_en_reg <= 1'b0;
            dma_clear_on_read_reg <= 1'b0;
            dsd_reg <= `ADCCT_RST_DSD;
            mask_reg <= `ADCCT_RST_MASK;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `ADCCT_OFF_TIMING: cmp_field_reg <= reg_wdata[1:0];
                `ADCCT_OFF_DMA:
                begin
                    dma_en_reg <= reg_wdata[`ADCCT_DMA_EN];
                    dma_clear_on_read_reg <= reg_wdata[`ADCCT_DMA_DMA_CLEAR_ON_READ];
                end
                `ADCCT_OFF_DSD: dsd_reg <= reg_wdata[7:0];
                `ADCCT_OFF_MASK: mask_reg <= reg_wdata[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg <= ADC_IDLE;
            cnt_reg <= 8'h00;
            cur_ch_reg <= 4'h0;
            chain_reg <= 1'b0;
            first_rep_reg <= 1'b0;
            bug_active_reg <= 1'b0;
            bug_pending_reg <= 1'b0;
        end
        else if (abort_now)
        begin
            state_reg <= ADC_IDLE;
            chain_reg <= 1'b0;
            bug_active_reg <= 1'b0;
            first_rep_reg <= 1'b0;
            bug_pending_reg <= 1'b1;
        end
        else if (can_run)
        begin
            case (state_reg)
                ADC_IDLE:
                begin
                    if (start_trig)
                    begin
                        state_reg <= first_state;
                        cnt_reg <= first_cnt;
                        cur_ch_reg <= {1'b0, link.trig_ch};
                        chain_reg <= 1'b0;
                    end
                    else if (start_chain)
                    begin
                        state_reg <= first_state;
                        cnt_reg <= first_cnt;
                        cur_ch_reg <= first_ch;
                        chain_reg <= 1'b1;
                        bug_active_reg <= bug_pending_reg;
                        first_rep_reg <= bug_pending_reg;
                        bug_pending_reg <= 1'b0;
                    end
                end
                ADC_DECODE:
                begin
                    cnt_reg <= cnt_reg - 8'h01;
                    if (cnt_reg <= 8'h01)
                    begin
                        state_reg <= ADC_CONVERT;
                        cnt_reg <= conv_len;
                    end
                end
                ADC_CONVERT:
                begin
                    cnt_reg <= cnt_reg - 8'h01;
                    if (cnt_reg <= 8'h01)
                    begin
                        state_reg <= ADC_DONE;
                    end
                end
                ADC_DONE:
                begin
                    if (conv_done)
                    begin
                        state_reg <= ADC_IDLE;
                        if (chain_reg)
                        begin
                            if (first_rep_reg)
                            begin
                                // The first channel is converted a second time.
                                first_rep_reg <= 1'b0;
                                state_reg <= first_state;
                                cnt_reg <= first_cnt;
                            end
                            else if (!chain_over)
                            begin
                                state_reg <= first_state;
                                cnt_reg <= first_cnt;
                                cur_ch_reg <= nxt_ch;
                            end
                            else if (scan_reg && start_reg && !abort_reg)
                            begin
                                state_reg <= first_state;
                                cnt_reg <= first_cnt;
                                cur_ch_reg <= first_ch;
                                bug_active_reg <= 1'b0;
                            end
                            else
                            begin
                                chain_reg <= 1'b0;
                                bug_active_reg <= 1'b0;
                            end
                        end
                    end
                end
                default: state_reg <= ADC_IDLE;
            endcase
        end
    end

    // Every finished triggered conversion asks the trigger unit for the next command.
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            next_cmd_reg <= 1'b0;
        end
        else
        begin
            next_cmd_reg <= conv_done && !chain_reg;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            data_reg <= 16'h0000;
        end
        else if (conv_done)
        begin
            data_reg <= result;
        end
        else if (reg_rd && (reg_addr == `ADCCT_OFF_DATA))
        begin
            data_reg[15] <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            rdata_reg <= 16'h0000;
        end
        else if (reg_rd)
        begin
            case (reg_addr)
                `ADCCT_OFF_MAIN: rdata_reg <= {11'h000, half_reg, ete_reg, scan_reg,
                                               abort_reg, start_reg};
                `ADCCT_OFF_TIMING: rdata_reg <= {14'h0000, cmp_field_reg};
                `ADCCT_OFF_DMA: rdata_reg <= {14'h0000, dma_clear_on_read_reg, dma_en_reg};
                `ADCCT_OFF_DSD: rdata_reg <= {8'h00, dsd_reg};
                `ADCCT_OFF_MASK: rdata_reg <= {8'h00, mask_reg};
                `ADCCT_OFF_STAT: rdata_reg <= {9'h000, data_reg[15], gated_reg, stuck_reg,
                                               bug_pending_reg, abort_reg, chain_reg,
                                               state_reg != ADC_IDLE};
                `ADCCT_OFF_DATA: rdata_reg <= data_reg;
                default: rdata_reg <= 16'h0000;
            endcase
        end
        else
        begin
            rdata_reg <= 16'h0000;
        end
    end

    adcct_buf2 #(
        .W(16),
        .D(2)
    ) u_buf (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .in_valid(conv_done && dma_en_reg),
        .in_ready(buf_in_ready),
        .in_data(result),
        .out_valid(buf_out_valid),
        .out_ready(buf_out_ready),
        .out_data(link.dma_data)
    );

    // Clear-on-read was meant to hold the request until the data are read, but the
    // request drops by itself and the word is lost, so the DMA side never sees it.
    assign link.dma_valid = buf_out_valid && !dma_clear_on_read_reg;
    assign buf_out_ready = link.dma_ready || dma_clear_on_read_reg;
    assign link.next_cmd = next_cmd_reg;
    assign reg_rdata = rdata_reg;
    assign mux_ch = cur_ch_reg[2:0];
    assign mux_decode = state_reg == ADC_CONVERT;
endmodule // adcct_adc
`default_nettype wire

// file: src/adcct_ctu.sv
// Purpose: Trigger unit end: timer requests, trigger handshake, result sink.
// Assumes: Software port strobes are one cycle; read data follow one cycle later.
// Notes: Waits for a next-command request after each trigger it sends.
`timescale 1ns/1ps
`default_nettype none
`include "adcct_defines.svh"
module adcct_ctu (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Link to the converter
    adcct_link_if.ctu link,
    // Software register port
    input wire adcct_pkg::adcct_addr_t reg_addr,
    input wire adcct_pkg::adcct_word_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output adcct_pkg::adcct_word_t reg_rdata,
    // Timer events and mode control
    input wire logic timer_req,
    input wire logic stop_req
);
    import adcct_pkg::*;

    logic tm_reg;
    logic ten_reg;
    adcct_ch_t ch_reg;
    logic accept_reg;
    logic [`ADCCT_CTU_GATE_CYC-1:0] gate_sr_reg;
    logic pending_reg;
    logic wait_reg;
    logic trig_reg;
    adcct_word_t last_reg;
    adcct_word_t count_reg;
    adcct_word_t rdata_reg;
    logic gated;
    logic issue;

    // The unit's clock stops three cycles after the stop request, later than the converter.
    assign gated = gate_sr_reg[`ADCCT_CTU_GATE_CYC-1];
    // Trigger mode keeps feeding triggers; with the enable low, timer requests wait.
    assign issue = !wait_reg && !gated && tm_reg && ten_reg && pending_reg;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            gate_sr_reg <= '0;
        end
        else
        begin
            gate_sr_reg <= {gate_sr_reg[`ADCCT_CTU_GATE_CYC-2:0], stop_req};
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            {ch_reg, ten_reg, tm_reg} <= `ADCCT_RST_EVT;
            accept_reg <= 1'b0;
        end
        else if (reg_wr && (reg_addr == `ADCCT_OFF_EVT))
        begin
            {ch_reg, ten_reg, tm_reg} <= reg_wdata[4:0];
        end
        else if (reg_wr && (reg_addr == `ADCCT_OFF_ACC))
        begin
            accept_reg <= reg_wdata[0];
        end
    end

    // A new timer request wins over the clear of the one being served.
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            pending_reg <= 1'b0;
        end
        else if (timer_req)
        begin
            pending_reg <= 1'b1;
        end
        else if (issue)
        begin
            pending_reg <= 1'b0;
        end
    end

    // A trigger lost in the converter leaves this end waiting for good.
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            wait_reg <= 1'b0;
            trig_reg <= 1'b0;
        end
        else
        begin
            trig_reg <= issue;
            if (issue)
            begin
                wait_reg <= 1'b1;
            end
            else if (link.next_cmd && !gated)
            begin
                wait_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            last_reg <= 16'h0000;
            count_reg <= 16'h0000;
        end
        else if (link.dma_valid && link.dma_ready)
        begin
            last_reg <= link.dma_data;
            count_reg <= count_reg + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            rdata_reg <= 16'h0000;
        end
        else if (reg_rd)
        begin
            case (reg_addr)
                `ADCCT_OFF_EVT: rdata_reg <= {11'h000, ch_reg, ten_reg, tm_reg};
                `ADCCT_OFF_ACC: rdata_reg <= {15'h0000, accept_reg};
                `ADCCT_OFF_CSTAT: rdata_reg <= {13'h0000, gated, pending_reg, wait_reg};
                `ADCCT_OFF_LAST: rdata_reg <= last_reg;
                `ADCCT_OFF_CNT: rdata_reg <= count_reg;
                default: rdata_reg <= 16'h0000;
            endcase
        end
        else
        begin
            rdata_reg <= 16'h0000;
        end
    end

    assign link.trig = trig_reg;
    assign link.trig_ch = ch_reg;
    assign link.dma_ready = accept_reg;
    assign reg_rdata = rdata_reg;
endmodule // adcct_ctu
`default_nettype wire

// file: bench/adcct_asserts.sv
// Purpose: Checks the trigger handshake and result stream on the link.
// Assumes: One clock, reset active low.
// Notes: A counter measures each trigger to its next-command request.
`timescale 1ns/1ps
`default_nettype none
module adcct_asserts (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Link
    input wire logic trig,
    input wire logic next_cmd,
    input wire logic dma_valid,
    input wire logic dma_ready,
    input wire logic [15:0] dma_data
);
    logic wait_reg;
    logic [8:0] cnt_reg;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            wait_reg <= 1'b0;
            cnt_reg <= 9'h000;
        end
        else
        begin
            wait_reg <= trig || (wait_reg && !next_cmd);
            cnt_reg <= trig ? 9'h001 : cnt_reg + 9'h001;
        end
    end
    trig_pulse_a: assert property (trig |=> !trig) else $error("trigger too long");
    next_pulse_a: assert property (next_cmd |=> !next_cmd) else $error("request too long");
    trig_order_a: assert property (trig |-> !wait_reg) else $error("trigger before request");
    next_pair_a: assert property (next_cmd |-> wait_reg && cnt_reg >= 9'h00d)
        else $error("request too early");
    next_bound_a: assert property (trig |-> ##[13:300] next_cmd) else $error("no request");
    data_tag_a: assert property (dma_valid |-> dma_data[15]) else $error("word untagged");
    valid_hold_a: assert property (dma_valid && !dma_ready |=> dma_valid)
        else $error("word withdrawn");
    data_hold_a: assert property (dma_valid && !dma_ready |=> $stable(dma_data))
        else $error("word changed");
endmodule // adcct_asserts
`default_nettype wire

// file: bench/adc_chain_trigger_control_bench.sv
// Purpose: Drives both register ports and checks the link end to end.
// Assumes: Both ends on one clock.
// Notes: Gating is exercised only with the unit's trigger enable off, so no trigger is lost.
`timescale 1ns/1ps
`default_nettype none
`include "adcct_defines.svh"
module adc_chain_trigger_control_bench;
    import adcct_pkg::*;
    logic clk_sys, resetn, tmr, md_d, mdec, stp;
    logic wr_s[2];
    logic rd_s[2];
    adcct_addr_t addr[2];
    adcct_word_t wd[2];
    adcct_word_t rdat[2];
    adcct_word_t v;
    logic [2:0] mch;
    logic [2:0] q[$];
    int n_mismatch, n_tests, i, n;
    int ds[4] = '{0, 2, 4, 5};
    int mn[4] = '{8, 8, 24, 24};
    int ex[4] = '{13, 15, 15, 15};
    adcct_link_if link();
    adcct_adc i_adcct_adc (.clk_sys(clk_sys), .resetn(resetn), .link(link.adc),
        .reg_addr(addr[0]), .reg_wdata(wd[0]), .reg_wr(wr_s[0]), .reg_rd(rd_s[0]),
        .reg_rdata(rdat[0]), .sample_data(12'h5a3), .stop_req(stp), .mux_ch(mch),
        .mux_decode(mdec));
    adcct_ctu i_adcct_ctu (.clk_sys(clk_sys), .resetn(resetn), .link(link.ctu),
        .reg_addr(addr[1]), .reg_wdata(wd[1]), .reg_wr(wr_s[1]), .reg_rd(rd_s[1]),
        .reg_rdata(rdat[1]), .timer_req(tmr), .stop_req(stp));
    adcct_asserts i_adcct_asserts (.clk_sys(clk_sys), .resetn(resetn), .trig(link.trig),
        .next_cmd(link.next_cmd), .dma_valid(link.dma_valid), .dma_ready(link.dma_ready),
        .dma_data(link.dma_data));
    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        md_d <= mdec;
        if (mdec && !md_d)
            q.push_back(mch);
    end
    task automatic give_verdict;
        if (n_mismatch == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string s, input adcct_word_t got, input adcct_word_t exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", s, exp, got);
        end
    endtask
    // Strobes drop one edge before the next access may raise them again.
    task automatic wr(input int c, input adcct_addr_t a, input int d);
        addr[c] <= a;
        wd[c] <= 16'(d);
        wr_s[c] <= 1'b1;
        @(posedge clk_sys);
        wr_s[c] <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input int c, input adcct_addr_t a);
        addr[c] <= a;
        rd_s[c] <= 1'b1;
        @(posedge clk_sys);
        rd_s[c] <= 1'b0;
        #1 v = rdat[c];
        @(posedge clk_sys);
    endtask
    task automatic hang(input int lim);
        if (n >= lim)
        begin
            chk("wait", 16'h0000, 16'h0001);
            give_verdict();
        end
    endtask
    // Counts edges from the trigger to the next-command request.
    task automatic conv(input int exp);
        n = 0;
        tmr <= 1'b1;
        @(posedge clk_sys);
        tmr <= 1'b0;
        do begin @(posedge clk_sys); n++; end while (link.trig !== 1'b1 && n < 60);
        hang(60);
        n = 0;
        do begin @(posedge clk_sys); n++; end while (link.next_cmd !== 1'b1 && n < 400);
        hang(400);
        chk("latency", 16'(n), 16'(exp));
    endtask
    initial
    begin
        resetn = 1'b0;
        tmr = 1'b0;
        stp = 1'b0;
        addr = '{4'h0, 4'h0};
        wd = '{16'h0000, 16'h0000};
        wr_s = '{1'b0, 1'b0};
        rd_s = '{1'b0, 1'b0};
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        rd(0, `ADCCT_OFF_TIMING);
        chk("timing", v, 16'h0001);
        rd(0, 4'hf);
        chk("unmapped", v, 16'h0000);
        wr(0, `ADCCT_OFF_DMA, 1);
        wr(0, `ADCCT_OFF_MAIN, 8);
        wr(1, `ADCCT_OFF_EVT, 11);
        for (i = 0; i < 4; i++)
        begin
            wr(0, `ADCCT_OFF_TIMING, i == 0 ? 0 : 1);
            wr(0, `ADCCT_OFF_DSD, ds[i]);
            wr(0, `ADCCT_OFF_MAIN, mn[i]);
            conv(ex[i]);
            wr(1, `ADCCT_OFF_ACC, 1);
        end
        rd(1, `ADCCT_OFF_CNT);
        chk("count", v, 16'h0004);
        rd(1, `ADCCT_OFF_LAST);
        chk("last", v, 16'ha5a3);
        wr(0, `ADCCT_OFF_DMA, 3);
        conv(15);
        rd(1, `ADCCT_OFF_CNT);
        chk("dropped", v, 16'h0004);
        wr(0, `ADCCT_OFF_DMA, 1);
        wr(1, `ADCCT_OFF_EVT, 9);
        stp <= 1'b1;
        tmr <= 1'b1;
        @(posedge clk_sys);
        tmr <= 1'b0;
        rd(1, `ADCCT_OFF_CSTAT);
        chk("unit early", 16'(v[2:1]), 16'h0001);
        rd(0, `ADCCT_OFF_STAT);
        chk("adc gated", 16'(v[5]), 16'h0001);
        rd(1, `ADCCT_OFF_CSTAT);
        chk("unit gated", 16'(v[2:1]), 16'h0003);
        stp <= 1'b0;
        wr(1, `ADCCT_OFF_EVT, 11);
        repeat (30) @(posedge clk_sys);
        rd(1, `ADCCT_OFF_CNT);
        chk("resumed", v, 16'h0005);
        wr(1, `ADCCT_OFF_EVT, 0);
        wr(0, `ADCCT_OFF_MAIN, 0);
        wr(0, `ADCCT_OFF_MASK, 7);
        wr(0, `ADCCT_OFF_DSD, 0);
        wr(0, `ADCCT_OFF_MAIN, 5);
        repeat (20) @(posedge clk_sys);
        rd(0, `ADCCT_OFF_STAT);
        chk("running", 16'(v[1]), 16'h0001);
        wr(0, `ADCCT_OFF_MAIN, 6);
        repeat (3) @(posedge clk_sys);
        rd(0, `ADCCT_OFF_STAT);
        chk("aborted", 16'({v[3], v[1]}), 16'h0002);
        q.delete();
        wr(0, `ADCCT_OFF_MAIN, 1);
        n = 0;
        do begin rd(0, `ADCCT_OFF_STAT); n++; end while (v[0] !== 1'b0 && n < 100);
        hang(100);
        chk("chain", 16'({q.size(), q[0], q[1], q[2]}), 16'h0601);
        give_verdict();
    end
endmodule // adc_chain_trigger_control_bench
`default_nettype wire
